// file: lsc_command_ctrl.sv
// Command byte decoder, control register and power/enable control of the light sensor.
`timescale 1ns/100ps

// Notes on behaviour
// [RL1] Host sets bit 7 of each command byte so it is taken as a command.
// [RL2] Transaction field 11 turns the low five bits into a special-function code.
// [RL3] Type 00 keeps the same register per byte; type 01 advances the index.
// [RL4] Other transactions take the low five bits as the target register index.
// [RL5] Special code 00001 clears the pending interrupt once, with no data byte.
// [RL6] With integration time zero, special code 00010 stops the manual integration.
// [RL7] With integration time zero, special code 00011 starts a manual integration.
// [RL8] Length of each manual integration is measured and readable via timer registers.
// [RL9] Special code 00000 and codes x11xx are reserved and do nothing.
// [RL10] Control register resets to zero: powered down, disabled, flags clear.
// [RL11] Host writes zeros to control bits 7:6 and 3:2.
// [RL12] Control bit 5 reads one while the interrupt is asserted.
// [RL13] Control bit 4 is set once the converters complete an integration cycle.
// [RL14] Control bit 1 enables both converter channels; zero disables them.
// [RL15] Control bit 0 powers the device on; zero powers it off.
// [RL16] Conversions proceed only while power and enable bits are both set.
// [RL17] Host waits 2 ms after power-on before setting the enable bit.
// [RL18] Host finishes configuration before setting the enable bit.
// [RL19] Writes to the read-only interrupt and valid bits leave them unchanged.
module lsc_command_ctrl #(
  parameter int TICK_CYCLES = lsc_pkg::TIMER_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Received and requested bytes from the serial engine
  input  wire logic       rx_valid,
  input  wire logic       rx_first,
  input  wire logic [7:0] rx_data,
  input  wire logic       tx_req,
  output logic      [7:0] tx_data,
  // Access to registers kept outside this block
  output logic      [4:0] reg_index,
  output logic            ext_wr,
  output logic      [7:0] ext_wdata,
  input  wire logic [7:0] ext_rdata,
  input  wire logic [7:0] integration_time_setting,
  // Converter and interrupt side
  input  wire logic       adc_done,
  input  wire logic       irq_set,
  output logic            power_on,
  output logic            adc_enable,
  output logic            convert_active,
  output logic            irq_pending_flag,
  output logic            adc_valid,
  output logic            manual_integ_active
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [1:0] trans_mode;
  logic [7:0] next_tx_data;

  lsc_mtimer_if mt ();

  // ---------------------------------------------------------------------------
  // Byte decode
  // ---------------------------------------------------------------------------
  // A first byte with bit 7 high is a command; every other byte is data.
  wire       cmd_byte  = rx_valid && rx_first && rx_data[lsc_pkg::CMD_BIT]; // [RL1]
  wire       data_wr   = rx_valid && !cmd_byte;
  wire [1:0] cmd_trans = rx_data[lsc_pkg::TRANS_HI:lsc_pkg::TRANS_LO];
  wire [4:0] cmd_addr  = rx_data[lsc_pkg::ADDR_HI:0];
  wire       special   = cmd_byte && (cmd_trans == lsc_pkg::TRANS_SPECIAL); // [RL2]
  wire       index_cmd = cmd_byte && !special; // [RL4]
  wire       advance   = (data_wr || tx_req) && (trans_mode == lsc_pkg::TRANS_AUTOINC); // [RL3]

  // Special functions; every other code, reserved ones included, does nothing.
  wire manual_mode = (integration_time_setting == lsc_pkg::INTEGRATION_TIME_SETTING_MANUAL);
  wire sf_clear    = special && (cmd_addr == lsc_pkg::SF_IRQ_CLEAR); // [RL5] [RL9]
  wire sf_stop     = special && (cmd_addr == lsc_pkg::SF_STOP_MANUAL) && manual_mode; // [RL6]
  wire sf_start    = special && (cmd_addr == lsc_pkg::SF_START_MANUAL) && manual_mode; // [RL7]

  // Control register write and its read image; reserved bits read zero.
  wire       ctrl_wr   = data_wr && (reg_index == lsc_pkg::REG_CONTROL);
  wire [7:0] ctrl_read = {2'b00, irq_pending_flag, adc_valid, 2'b00, adc_enable, power_on}; // [RL12] [RL13]

  assign mt.start = sf_start;
  assign mt.stop  = sf_stop;

  // Read data for the register currently addressed.
  always_comb begin
    unique case (reg_index)
      lsc_pkg::REG_CONTROL:    next_tx_data = ctrl_read;
      lsc_pkg::REG_TIMER_LOW:  next_tx_data = mt.count[7:0]; // [RL8]
      lsc_pkg::REG_TIMER_HIGH: next_tx_data = mt.count[15:8];
      default:                 next_tx_data = ext_rdata;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Command register
  // ---------------------------------------------------------------------------
  // Index and transaction type; a special command leaves both untouched.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_index  <= lsc_pkg::CMD_RESET[4:0];
      trans_mode <= lsc_pkg::CMD_RESET[6:5];
    end else if (index_cmd) begin
      reg_index  <= cmd_addr; // [RL4]
      trans_mode <= cmd_trans;
    end else if (advance) begin
      reg_index  <= reg_index + 5'h01; // [RL3]
    end
  end

  // ---------------------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------------------
  // Only the power and enable bits are writable; bits 7:6 and 3:2 are dropped.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      power_on   <= lsc_pkg::CTRL_RESET[lsc_pkg::CTRL_POWER]; // [RL10]
      adc_enable <= lsc_pkg::CTRL_RESET[lsc_pkg::CTRL_ADC_EN];
    end else if (ctrl_wr) begin // [RL19]
      power_on   <= rx_data[lsc_pkg::CTRL_POWER]; // [RL15]
      adc_enable <= rx_data[lsc_pkg::CTRL_ADC_EN]; // [RL14]
    end
  end

  // Status flags: hardware sets, a set beats a clear in the same cycle.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_pending_flag <= lsc_pkg::CTRL_RESET[lsc_pkg::CTRL_IRQ];
      adc_valid        <= lsc_pkg::CTRL_RESET[lsc_pkg::CTRL_VALID];
    end else begin
      if (irq_set) begin
        irq_pending_flag <= 1'b1;
      end else if (sf_clear) begin
        irq_pending_flag <= 1'b0; // [RL5]
      end
      if (convert_active && adc_done) begin
        adc_valid <= 1'b1; // [RL13]
      end else if (!convert_active) begin
        adc_valid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs toward other registers and the host
  // ---------------------------------------------------------------------------
  // Data bytes for other indices are passed out; read data is latched on request.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_wr    <= 1'b0;
      ext_wdata <= 8'h00;
      tx_data   <= 8'h00;
    end else begin
      ext_wr    <= data_wr && !ctrl_wr;
      ext_wdata <= data_wr ? rx_data : ext_wdata;
      tx_data   <= tx_req ? next_tx_data : tx_data;
    end
  end

  // Converters run only with both power and enable set.
  assign convert_active      = power_on && adc_enable; // [RL16]
  assign manual_integ_active = mt.running;

  lsc_manual_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .mt      (mt)
  );

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_start_cmd;
    special && cmd_addr == lsc_pkg::SF_START_MANUAL && manual_mode;
  endsequence

  sequence s_stop_cmd;
    special && cmd_addr == lsc_pkg::SF_STOP_MANUAL && manual_mode && !sf_start;
  endsequence

  property p_index_load;
    index_cmd |=> reg_index == $past(cmd_addr);
  endproperty
  a_index_load: assert property (p_index_load) else $error("Index not loaded from command."); // [RL4]

  property p_special_keeps_index;
    special && !advance |=> $stable(reg_index);
  endproperty
  a_special_keeps_index: assert property (p_special_keeps_index) else $error("Special command moved index."); // [RL2]

  property p_index_step;
    !cmd_byte && (data_wr || tx_req) |=>
      reg_index == (($past(trans_mode) == lsc_pkg::TRANS_AUTOINC) ? $past(reg_index) + 5'h01 : $past(reg_index));
  endproperty
  a_index_step: assert property (p_index_step) else $error("Index step wrong for mode."); // [RL3]

  property p_irq_clear;
    sf_clear && !irq_set |=> !irq_pending_flag ##1 (irq_pending_flag == $past(irq_set));
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("Interrupt clear failed."); // [RL5]

  // A stop may follow the start at once; the run then ends on that stop alone.
  sequence s_run_two;
    manual_integ_active ##1 (manual_integ_active || $past(sf_stop));
  endsequence

  property p_manual_start;
    s_start_cmd |=> s_run_two;
  endproperty
  a_manual_start: assert property (p_manual_start) else $error("Manual start failed."); // [RL7]

  property p_manual_stop;
    s_stop_cmd |=> !manual_integ_active ##1 ($stable(mt.count) || $past(sf_start));
  endproperty
  a_manual_stop: assert property (p_manual_stop) else $error("Manual stop failed."); // [RL6] [RL8]

  property p_reserved_code;
    special && !sf_clear && !sf_start && !sf_stop && !irq_set |=>
      $stable(irq_pending_flag) && $stable(manual_integ_active);
  endproperty
  a_reserved_code: assert property (p_reserved_code) else $error("Reserved code acted."); // [RL9]

  property p_ro_flags;
    ctrl_wr && !irq_set && !adc_done && convert_active && !sf_clear |=>
      $stable(irq_pending_flag) && $stable(adc_valid);
  endproperty
  a_ro_flags: assert property (p_ro_flags) else $error("Write altered read-only flag."); // [RL19]

  property p_ctrl_read;
    tx_req && reg_index == lsc_pkg::REG_CONTROL |=>
      tx_data[7:6] == 2'b00 && tx_data[3:2] == 2'b00 &&
      tx_data[lsc_pkg::CTRL_IRQ] == $past(irq_pending_flag) && tx_data[lsc_pkg::CTRL_VALID] == $past(adc_valid);
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("Control read image wrong."); // [RL12] [RL13]

  property p_ctrl_write;
    ctrl_wr |=> power_on == $past(rx_data[0]) && adc_enable == $past(rx_data[1]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("Control write not stored."); // [RL14] [RL15]

  property p_no_convert;
    !convert_active |=> !adc_valid;
  endproperty
  a_no_convert: assert property (p_no_convert) else $error("Valid while converters off."); // [RL16]

  // ---------------------------------------------------------------------------
  // Assertions on hardware-set flags, the byte path and the timer
  // ---------------------------------------------------------------------------
  // A hardware event must show in its flag on the very next cycle.
  property p_irq_set;
    irq_set |=> irq_pending_flag;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("Interrupt event not flagged."); // [RL12]

  property p_valid_set;
    convert_active && adc_done |=> adc_valid;
  endproperty
  a_valid_set: assert property (p_valid_set) else $error("Completed cycle not flagged valid."); // [RL13]

  // Data bytes for other indices leave the block; a control byte reaches ext_wdata but raises no ext_wr.
  property p_ext_write;
    data_wr && !ctrl_wr |=> ext_wr && ext_wdata == $past(rx_data);
  endproperty
  a_ext_write: assert property (p_ext_write) else $error("Data byte not passed out."); // [RL4]

  property p_ctrl_no_ext;
    ctrl_wr |=> !ext_wr;
  endproperty
  a_ctrl_no_ext: assert property (p_ctrl_no_ext) else $error("Control write leaked outside."); // [RL4]

  // A start outside manual timing mode leaves an idle timer idle.
  sequence s_start_refused;
    special && cmd_addr == lsc_pkg::SF_START_MANUAL && !manual_mode && !mt.running;
  endsequence

  property p_start_refused;
    s_start_refused |=> !manual_integ_active;
  endproperty
  a_start_refused: assert property (p_start_refused) else $error("Start acted outside manual mode."); // [RL7]

  // An accepted start clears the measured length before counting again.
  property p_manual_restart;
    s_start_cmd |=> mt.count == '0;
  endproperty
  a_manual_restart: assert property (p_manual_restart) else $error("Start did not clear the timer."); // [RL8]

  // Timer reads return the measured length as it stood at the request.
  sequence s_timer_low_read;
    tx_req && reg_index == lsc_pkg::REG_TIMER_LOW;
  endsequence

  sequence s_timer_high_read;
    tx_req && reg_index == lsc_pkg::REG_TIMER_HIGH;
  endsequence

  property p_timer_low;
    s_timer_low_read |=> tx_data == $past(mt.count[7:0]);
  endproperty
  a_timer_low: assert property (p_timer_low) else $error("Timer low byte read wrong."); // [RL8]

  property p_timer_high;
    s_timer_high_read |=> tx_data == $past(mt.count[15:8]);
  endproperty
  a_timer_high: assert property (p_timer_high) else $error("Timer high byte read wrong."); // [RL8]

endmodule

// file: lsc_pkg.sv
// Shared constants for the light sensor command and power control block.
package lsc_pkg;

  // ---------------------------------------------------------------------------
  // Command byte layout
  // ---------------------------------------------------------------------------
  localparam int         CMD_BIT        = 7;
  localparam int         TRANS_HI       = 6;
  localparam int         TRANS_LO       = 5;
  localparam int         ADDR_HI        = 4;
  localparam logic [7:0] CMD_RESET      = 8'h00;
  localparam logic [1:0] TRANS_REPEAT   = 2'h0;
  localparam logic [1:0] TRANS_AUTOINC  = 2'h1;
  localparam logic [1:0] TRANS_SPECIAL  = 2'h3;
  localparam logic [4:0] SF_IRQ_CLEAR   = 5'h01;
  localparam logic [4:0] SF_STOP_MANUAL = 5'h02;
  localparam logic [4:0] SF_START_MANUAL = 5'h03;

  // ---------------------------------------------------------------------------
  // Register indices and control register fields
  // ---------------------------------------------------------------------------
  localparam logic [4:0] REG_CONTROL    = 5'h00;
  localparam logic [4:0] REG_TIMER_LOW  = 5'h18;
  localparam logic [4:0] REG_TIMER_HIGH = 5'h19;
  localparam int         CTRL_POWER     = 0;
  localparam int         CTRL_ADC_EN    = 1;
  localparam int         CTRL_VALID     = 4;
  localparam int         CTRL_IRQ       = 5;
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [7:0] INTEGRATION_TIME_SETTING_MANUAL   = 8'h00;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int         CLK_HZ            = 20_000_000;
  localparam int         TIMER_TICK_NS     = 1000;
  localparam int         TIMER_TICK_CYCLES = (TIMER_TICK_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int         TIMER_W           = 16;

endpackage

// file: lsc_mtimer_if.sv
// Carrier between the command decoder and the manual integration timer.
`timescale 1ns/100ps
interface lsc_mtimer_if;
  logic                        start;
  logic                        stop;
  logic                        running;
  logic [lsc_pkg::TIMER_W-1:0] count;

  // Decoder side issues commands and reads the result.
  modport ctrl (
    output start,
    output stop,
    input  running,
    input  count
  );

  // Timer side obeys commands and reports the measurement.
  modport timer (
    input  start,
    input  stop,
    output running,
    output count
  );
endinterface

// file: lsc_manual_timer.sv
// Manual integration timer that measures the length of a manual integration.
`timescale 1ns/100ps
module lsc_manual_timer #(
  parameter int TICK_CYCLES = lsc_pkg::TIMER_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   reset_n,
  // Command and result carrier
  lsc_mtimer_if.timer mt
);

  typedef enum logic {LSC_MT_IDLE, LSC_MT_RUN} lsc_mt_state_t;

  localparam int PW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  lsc_mt_state_t               state;
  lsc_mt_state_t               next_state;
  logic [PW-1:0]               prescale;
  logic [lsc_pkg::TIMER_W-1:0] count;

  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------
  // A tick marks the end of one timer unit; the count saturates at all ones.
  wire tick      = (prescale == PW'(TICK_CYCLES - 1));
  wire saturated = &count;

  // Start restarts the measurement, stop freezes it.
  always_comb begin
    next_state = state;
    unique case (state)
      LSC_MT_IDLE: if (mt.start) next_state = LSC_MT_RUN;
      LSC_MT_RUN:  if (mt.stop && !mt.start) next_state = LSC_MT_IDLE;
    endcase
  end

  // State, prescaler and measured length.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state    <= LSC_MT_IDLE;
      prescale <= '0;
      count    <= '0;
    end else begin
      state    <= next_state;
      prescale <= (mt.start || tick || state == LSC_MT_IDLE) ? '0 : prescale + 1'b1;
      if (mt.start) begin
        count <= '0;
      end else if (state == LSC_MT_RUN && tick && !saturated) begin
        count <= count + 1'b1; // [RL8]
      end
    end
  end

  assign mt.running = (state == LSC_MT_RUN);
  assign mt.count   = count;

endmodule

// file: lsc_host_model.sv
// Host side model that writes command and data bytes and reads bytes back.
`timescale 1ns/100ps
module lsc_host_model (
  // Clock
  input  wire logic       clk,
  // Byte stream towards the device
  output logic            rx_valid,
  output logic            rx_first,
  output logic      [7:0] rx_data,
  output logic            tx_req,
  input  wire logic [7:0] tx_data
);
  // ---------------------------------------------------------------------------
  // Idle state
  // ---------------------------------------------------------------------------
  initial begin
    rx_valid = 1'b0;
    rx_first = 1'b0;
    rx_data  = 8'h00;
    tx_req   = 1'b0;
  end

  // ---------------------------------------------------------------------------
  // Transfers
  // ---------------------------------------------------------------------------
  // Sends one byte for one cycle; a command always carries its top bit set.
  task automatic put(input logic first, input logic [7:0] b);
    @(negedge clk);
    rx_valid = 1'b1;
    rx_first = first;
    rx_data  = first ? (b | 8'h80) : b;
    @(negedge clk);
    rx_valid = 1'b0;
    rx_first = 1'b0;
    rx_data  = ~rx_data; // Released data never shows the last byte.
  endtask

  // Requests one byte and takes it once the device has answered.
  task automatic get(output logic [7:0] b);
    @(negedge clk);
    tx_req = 1'b1;
    @(negedge clk);
    tx_req = 1'b0;
    b      = tx_data;
  endtask
endmodule

// file: light_sensor_command_and_power_ctrl_bench.sv
// Self-checking bench of the command decoder and power control block.
`timescale 1ns/100ps
module light_sensor_command_and_power_ctrl_bench;
  logic        clk;
  logic        reset_n;
  logic        rx_valid;
  logic        rx_first;
  logic  [7:0] rx_data;
  logic        tx_req;
  logic  [7:0] tx_data;
  logic  [4:0] reg_index;
  logic        ext_wr;
  logic  [7:0] ext_wdata;
  logic  [7:0] exp_q [$];
  logic  [7:0] ext_rdata;
  logic  [7:0] its;
  logic        adc_done;
  logic        irq_set;
  logic        power_on;
  logic        adc_enable;
  logic        convert_active;
  logic        irq_pending_flag;
  logic        adc_valid;
  logic        manual_integ_active;
  logic  [7:0] v;
  logic  [7:0] d;
  logic  [7:0] lo;
  logic  [4:0] idx;
  logic [15:0] cnt;
  integer      failures;
  integer      checked;
  integer      cycles;
  integer      seed;
  integer      exp_ctrl;
  logic  [7:0] rsv [4] = '{8'hE0, 8'hEC, 8'hED, 8'hFE};

  lsc_command_ctrl #(.TICK_CYCLES(2)) i_dut (
    .clk(clk), .reset_n(reset_n), .rx_valid(rx_valid), .rx_first(rx_first), .rx_data(rx_data),
    .tx_req(tx_req), .tx_data(tx_data), .reg_index(reg_index), .ext_wr(ext_wr), .ext_wdata(ext_wdata),
    .ext_rdata(ext_rdata), .integration_time_setting(its), .adc_done(adc_done), .irq_set(irq_set),
    .power_on(power_on), .adc_enable(adc_enable), .convert_active(convert_active),
    .irq_pending_flag(irq_pending_flag), .adc_valid(adc_valid), .manual_integ_active(manual_integ_active)
  );

  lsc_host_model i_host (
    .clk(clk), .rx_valid(rx_valid), .rx_first(rx_first), .rx_data(rx_data), .tx_req(tx_req), .tx_data(tx_data)
  );

  // ---------------------------------------------------------------------------
  // Clock and watchdog
  // ---------------------------------------------------------------------------
  // Clock at 50 ns period.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Cuts a hung run short.
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 60000) begin
      failures = failures + 1;
      stop_test();
    end
  end

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Counts a comparison and reports a mismatch.
  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    checked = checked + 1;
    if (g !== e) begin
      failures = failures + 1;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask

  // Gives one-cycle pulses on the converter or interrupt input.
  task automatic pulse(input bit irq);
    @(negedge clk);
    if (irq) irq_set = 1'b1; else adc_done = 1'b1;
    @(negedge clk);
    irq_set  = 1'b0;
    adc_done = 1'b0;
  endtask

  // Reads the control register and compares it with the bench model.
  task automatic ctrl_read();
    i_host.put(1'b1, 8'h80);
    i_host.get(v);
    chk("control", exp_ctrl[7:0], v);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    failures = 0; checked = 0; cycles = 0; seed = 42950; exp_ctrl = 0;
    reset_n = 1'b0; ext_rdata = 8'h00; its = 8'h05; adc_done = 1'b0; irq_set = 1'b0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    chk("outputs", 6'h00, {power_on, adc_enable, convert_active, irq_pending_flag, adc_valid, manual_integ_active});
    ctrl_read();
    // Power on while poking the read-only flags; reserved bits stay zero.
    i_host.put(1'b1, 8'h80);
    i_host.put(1'b0, 8'h31);
    chk("ext_wr_ctrl", 1'b0, ext_wr);
    exp_ctrl = 1;
    chk("power", 3'b100, {power_on, adc_enable, convert_active});
    ctrl_read();
    repeat (40000) @(negedge clk);
    i_host.put(1'b1, 8'h80);
    i_host.put(1'b0, 8'h03);
    exp_ctrl = 3;
    chk("enable", 3'b111, {power_on, adc_enable, convert_active});
    pulse(1'b0);
    exp_ctrl = exp_ctrl | 16;
    ctrl_read();
    pulse(1'b1);
    exp_ctrl = exp_ctrl | 32;
    ctrl_read();
    // Reserved special codes leave the interrupt pending.
    for (int i = 0; i < 4; i++) begin
      i_host.put(1'b1, rsv[i]);
      chk("irq_rsv", 1'b1, irq_pending_flag);
    end
    i_host.put(1'b1, 8'hE1);
    exp_ctrl = exp_ctrl & 8'hDF;
    chk("irq_clr", 1'b0, irq_pending_flag);
    ctrl_read();
    i_host.put(1'b1, 8'h80);
    i_host.put(1'b0, 8'h01);
    exp_ctrl = 1;
    @(negedge clk); // The valid flag drops one cycle after the converters stop.
    chk("disable", 2'b00, {convert_active, adc_valid});
    ctrl_read();
    // Auto-increment and repeat addressing with random indices and data.
    for (int i = 0; i < 4; i++) begin
      idx = 5'(($random(seed) & 15) + 1);
      i_host.put(1'b1, {3'b101, idx});
      chk("index", idx, reg_index);
      d = 8'($random(seed));
      i_host.put(1'b0, d);
      chk("wdata", d, ext_wdata);
      chk("ext_wr", 1'b1, ext_wr);
      chk("index_inc", 5'(idx + 1), reg_index);
      ext_rdata = 8'($random(seed));
      exp_q.push_back(ext_rdata);
      i_host.get(v);
      chk("rdata", exp_q.pop_front(), v);
      chk("index_inc2", 5'(idx + 2), reg_index);
      i_host.put(1'b1, {3'b100, idx});
      i_host.put(1'b0, d);
      i_host.get(v);
      chk("index_rep", idx, reg_index);
      chk("rdata_rep", ext_rdata, v);
    end
    // Manual integration only in manual timing mode.
    i_host.put(1'b1, 8'hE3);
    chk("manual_off", 1'b0, manual_integ_active);
    its = 8'h00;
    i_host.put(1'b1, 8'hE3);
    chk("manual_on", 1'b1, manual_integ_active);
    repeat (100) @(negedge clk);
    i_host.put(1'b1, 8'hE2);
    chk("manual_stop", 1'b0, manual_integ_active);
    for (int i = 0; i < 2; i++) begin
      i_host.put(1'b1, 8'h98);
      i_host.get(lo);
      i_host.put(1'b1, 8'h99);
      i_host.get(v);
      if (i == 0) cnt = {v, lo};
      chk("timer_hold", cnt, {v, lo});
      repeat (20) @(negedge clk);
    end
    chk("timer_len", 1'b1, cnt >= 16'h0032 && cnt <= 16'h0034);
    stop_test();
  end
endmodule
